/* logic/jtp_pkg.sv */
// Constants, state type and instruction codes for the test access port.
// Assumes one system clock domain and one link clock (the test clock).

package jtp_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths and captured values
  localparam int         IR_W         = 4;
  localparam int         ID_W         = 32;
  localparam logic [3:0] IR_CAPTURE   = 4'h1;
  localparam int         TLR_TMS_ONES = 5;
  localparam int         SYNC_STAGES  = 2;
  localparam int         EXT_CHAINS   = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Instruction codes
  localparam logic [3:0] INS_EXTEST   = 4'h0;
  localparam logic [3:0] INS_IDCODE   = 4'h1;
  localparam logic [3:0] INS_SAMPLE   = 4'h2;
  localparam logic [3:0] INS_PROG_LO  = 4'h4;
  localparam logic [3:0] INS_PROG_HI  = 4'h7;
  localparam logic [3:0] INS_ISCAN_LO = 4'h8;
  localparam logic [3:0] INS_ISCAN_HI = 4'h9;
  localparam logic [3:0] INS_BPSCN_LO = 4'hA;
  localparam logic [3:0] INS_BPSCN_HI = 4'hB;
  localparam logic [3:0] INS_BYPASS   = 4'hF;
  localparam logic [3:0] IR_RESET_VAL = INS_IDCODE;

  // External chain select bit positions
  localparam int CH_BSCAN = 0;
  localparam int CH_PROG  = 1;
  localparam int CH_ISCAN = 2;
  localparam int CH_BPSCN = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Controller states
  typedef enum logic [3:0] {
    ST_TLR, ST_RTI,
    ST_SEL_DR, ST_CAP_DR, ST_SH_DR, ST_EX1_DR, ST_PA_DR, ST_EX2_DR, ST_UPD_DR,
    ST_SEL_IR, ST_CAP_IR, ST_SH_IR, ST_EX1_IR, ST_PA_IR, ST_EX2_IR, ST_UPD_IR
  } jtp_state_type;

endpackage : jtp_pkg

/* logic/jtp_tap.sv */
// Test access port: state machine, instruction register, ID and bypass
// registers, and the serial path to the external scan chains.
// Assumes tck_i is the link clock from the test controller; external chains
// are clocked by tck_i and answer on chain_tdo_i in the same domain.
// There is no test-reset pin: the hold request and TMS ones reset the port.
`timescale 1ns/1ps
`default_nettype none

module jtp_tap
  import jtp_pkg::*;
#(
  // Arbitrary identification value, LSB kept at one
  parameter logic [31:0] ID_VALUE = 32'h1234_5001
) (
  // System clock domain
  input  wire logic                  clock_i,
  input  wire logic                  reset_i,
  input  wire logic                  ce_i,
  // Port enable controls
  input  wire logic                  port_enable_fuse_i,
  input  wire logic                  port_disable_bit_i,
  // Link pins
  input  wire logic                  tck_i,
  input  wire logic                  tms_i,
  input  wire logic                  tdi_i,
  output logic                       tdo_o,
  output logic                       tdo_oe_o,
  // Pin mode
  output logic                       port_active_o,
  output logic                       pins_as_io_o,
  output logic                       tap_pullup_o,
  // External chains, tck_i domain
  output logic [EXT_CHAINS-1:0]      chain_sel_o,
  output logic                       chain_capture_o,
  output logic                       chain_shift_o,
  output logic                       chain_update_o,
  output logic                       chain_tdi_o,
  input  wire logic [EXT_CHAINS-1:0] chain_tdo_i,
  // Instruction seen from the system domain
  output logic [IR_W-1:0]            instr_o,
  output logic                       instr_new_o,
  output logic                       run_idle_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Functions

  // Maps an instruction to its external chain, zero for internal ones
  // Unused codes fall through to zero, which routes TDO through bypass
  function automatic logic [EXT_CHAINS-1:0] chain_of(input logic [IR_W-1:0] ir);
    logic [EXT_CHAINS-1:0] sel;
    sel = '0;
    if (ir == INS_EXTEST || ir == INS_SAMPLE) begin
      sel[CH_BSCAN] = 1'b1;
    end else if (ir >= INS_PROG_LO && ir <= INS_PROG_HI) begin
      sel[CH_PROG] = 1'b1;
    end else if (ir >= INS_ISCAN_LO && ir <= INS_ISCAN_HI) begin
      sel[CH_ISCAN] = 1'b1;
    end else if (ir >= INS_BPSCN_LO && ir <= INS_BPSCN_HI) begin
      sel[CH_BPSCN] = 1'b1;
    end
    return sel;
  endfunction : chain_of

  // Next controller state from TMS
  function automatic jtp_state_type step(input jtp_state_type s, input logic tms);
    jtp_state_type n;
    n = ST_TLR;
    case (s)
      ST_TLR:    n = tms ? ST_TLR    : ST_RTI;
      ST_RTI:    n = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: n = tms ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR:  n = tms ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: n = tms ? ST_UPD_DR : ST_PA_DR;
      ST_PA_DR:  n = tms ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: n = tms ? ST_UPD_DR : ST_SH_DR;
      ST_UPD_DR: n = tms ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: n = tms ? ST_TLR    : ST_CAP_IR;
      ST_CAP_IR: n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR:  n = tms ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: n = tms ? ST_UPD_IR : ST_PA_IR;
      ST_PA_IR:  n = tms ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: n = tms ? ST_UPD_IR : ST_SH_IR;
      ST_UPD_IR: n = tms ? ST_SEL_DR : ST_RTI;
      default:   n = ST_TLR;
    endcase
    return n;
  endfunction : step

  ////////////////////////////////////////////////////////////////////////////
  // System domain: port enable and hold request

  logic       fuse_s1_ff;
  logic       fuse_s2_ff;
  logic       dis_s1_ff;
  logic       dis_s2_ff;
  logic       hold_ff;
  logic       enabled_ff;

  // Enable controls arrive from outside this clock, so synchronise first
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      fuse_s1_ff <= 1'b0;
      fuse_s2_ff <= 1'b0;
      dis_s1_ff  <= 1'b0;
      dis_s2_ff  <= 1'b0;
    end else if (ce_i) begin
      fuse_s1_ff <= port_enable_fuse_i;
      fuse_s2_ff <= fuse_s1_ff;
      dis_s1_ff  <= port_disable_bit_i;
      dis_s2_ff  <= dis_s1_ff;
    end
  end

  // enable and hold
  // Hold and enable are separate flops so each consumer reads a single bit
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      enabled_ff <= 1'b0;
      hold_ff    <= 1'b1;
    end else if (ce_i) begin
      enabled_ff <= fuse_s2_ff & ~dis_s2_ff;
      hold_ff    <= ~(fuse_s2_ff & ~dis_s2_ff);
    end
  end

  // Pins fall back to plain I/O whenever the port is not enabled
  assign port_active_o = enabled_ff;
  assign pins_as_io_o  = ~enabled_ff;
  assign tap_pullup_o  = enabled_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: hold crossing and controller

  logic          hold_t1_ff;
  logic          hold_t2_ff;
  jtp_state_type state_ff;
  jtp_state_type nxt_state;

  // Level crossing of the hold request into the test clock
  // The test clock may stand still for long spans, so the hold only takes
  // effect after two of its edges; a host sends TMS ones first anyway
  always_ff @(posedge tck_i) begin
    hold_t1_ff <= hold_ff;
    hold_t2_ff <= hold_t1_ff;
  end

  assign nxt_state = step(state_ff, tms_i);

  // reset state, also reached by five TMS ones
  // The hold always wins over TMS, so a disabled port cannot be steered
  always_ff @(posedge tck_i) begin
    if (hold_t2_ff) begin
      state_ff <= ST_TLR;
    end else begin
      state_ff <= nxt_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction register

  logic [IR_W-1:0] ir_sh_ff;
  logic [IR_W-1:0] ir_ff;
  logic            ir_tgl_ff;

  // capture 0x01 and shift LSB first
  // Loaded under hold as well, so the first Shift-IR never shows unknowns
  always_ff @(posedge tck_i) begin
    if (hold_t2_ff) begin
      ir_sh_ff <= IR_CAPTURE;
    end else if (state_ff == ST_CAP_IR) begin
      ir_sh_ff <= IR_CAPTURE;
    end else if (state_ff == ST_SH_IR) begin
      ir_sh_ff <= {tdi_i, ir_sh_ff[IR_W-1:1]};
    end
  end

  // latch on Update-IR, toggle marks a new word
  always_ff @(posedge tck_i) begin
    if (hold_t2_ff || state_ff == ST_TLR) begin
      ir_ff <= IR_RESET_VAL;
    end else if (state_ff == ST_UPD_IR) begin
      ir_ff <= ir_sh_ff;
    end
  end

  // Toggle on every Update-IR and on the reset to the identification code
  // by TMS ones; the hold clears the toggle instead, so instr_o can go stale
  always_ff @(posedge tck_i) begin
    if (hold_t2_ff) begin
      ir_tgl_ff <= 1'b0;
    end else if (state_ff == ST_UPD_IR) begin
      ir_tgl_ff <= ~ir_tgl_ff;
    end else if (state_ff == ST_TLR && ir_ff != IR_RESET_VAL) begin
      ir_tgl_ff <= ~ir_tgl_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal data registers: identification and bypass

  logic [ID_W-1:0] id_sh_ff;
  logic            byp_ff;
  logic            use_id;

  assign use_id = (ir_ff == INS_IDCODE);

  // capture then shift LSB first; no latched output here
  // Loaded during hold too, so a scan never shows unknown bits
  always_ff @(posedge tck_i) begin
    if (hold_t2_ff) begin
      id_sh_ff <= ID_VALUE;
    end else if (state_ff == ST_CAP_DR) begin
      id_sh_ff <= ID_VALUE;
    end else if (state_ff == ST_SH_DR && use_id) begin
      id_sh_ff <= {tdi_i, id_sh_ff[ID_W-1:1]};
    end
  end

  // Bypass captures zero, as usual for a one-bit path; cleared during hold
  always_ff @(posedge tck_i) begin
    if (hold_t2_ff) begin
      byp_ff <= 1'b0;
    end else if (state_ff == ST_CAP_DR) begin
      byp_ff <= 1'b0;
    end else if (state_ff == ST_SH_DR) begin
      byp_ff <= tdi_i;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // External chains

  // instruction steers chain selection
  // Debug chains sit on their own select bits, apart from the test registers
  assign chain_sel_o     = chain_of(ir_ff);
  assign chain_tdi_o     = tdi_i;
  // capture and shift strobes
  // Not qualified by the select: each chain must gate the strobes itself
  assign chain_capture_o = (state_ff == ST_CAP_DR) && !hold_t2_ff;
  assign chain_shift_o   = (state_ff == ST_SH_DR) && !hold_t2_ff;
  // update only in Update-DR, none in exit or pause
  assign chain_update_o  = (state_ff == ST_UPD_DR) && !hold_t2_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Serial output

  logic dr_bit;
  logic sh_bit;
  logic shifting;

  // data path mux
  // Unselected chains are masked so a stray chain output cannot reach TDO
  always_comb begin
    dr_bit = byp_ff;
    if (use_id) begin
      dr_bit = id_sh_ff[0];
    end else if (|chain_sel_o) begin
      dr_bit = |(chain_tdo_i & chain_sel_o);
    end
  end

  assign shifting = (state_ff == ST_SH_IR) || (state_ff == ST_SH_DR);
  assign sh_bit   = (state_ff == ST_SH_IR) ? ir_sh_ff[0] : dr_bit;

  // drive only while shifting; changes on the falling edge so the
  // far end samples a settled bit on the next rising edge
  always_ff @(negedge tck_i) begin
    if (hold_t2_ff) begin
      tdo_o    <= 1'b0;
      tdo_oe_o <= 1'b0;
    end else begin
      tdo_o    <= shifting ? sh_bit : 1'b0;
      tdo_oe_o <= shifting;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Instruction and idle status into the system domain

  logic            tgl_s1_ff;
  logic            tgl_s2_ff;
  logic            tgl_s3_ff;
  logic            idle_s1_ff;
  logic            idle_s2_ff;
  logic            rti_ff;
  logic [IR_W-1:0] instr_ff;
  logic            instr_new_ff;

  // Idle flag made in a flop so the crossing sees a glitch-free level
  // It mirrors the state register, in step with a decode of it
  always_ff @(posedge tck_i) begin
    if (hold_t2_ff) begin
      rti_ff <= 1'b0;
    end else begin
      rti_ff <= (nxt_state == ST_RTI);
    end
  end

  // Toggle handshake: ir_ff is stable long after the toggle flips,
  // because another change, by Update-IR or by the TMS-ones reset, needs at least three more test clocks
  // Limitation: a new instruction shows up about three system clocks late
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      tgl_s1_ff  <= 1'b0;
      tgl_s2_ff  <= 1'b0;
      tgl_s3_ff  <= 1'b0;
      idle_s1_ff <= 1'b0;
      idle_s2_ff <= 1'b0;
    end else if (ce_i) begin
      tgl_s1_ff  <= ir_tgl_ff;
      tgl_s2_ff  <= tgl_s1_ff;
      tgl_s3_ff  <= tgl_s2_ff;
      idle_s1_ff <= rti_ff;
      idle_s2_ff <= idle_s1_ff;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      instr_ff     <= IR_RESET_VAL;
      instr_new_ff <= 1'b0;
    end else if (ce_i) begin
      instr_new_ff <= tgl_s2_ff ^ tgl_s3_ff;
      if (tgl_s2_ff ^ tgl_s3_ff) begin
        instr_ff <= ir_ff;
      end
    end
  end

  assign instr_o     = instr_ff;
  assign instr_new_o = instr_new_ff;
  assign run_idle_o  = idle_s2_ff;

endmodule : jtp_tap

`default_nettype wire

/* sim/jtag_tap_controller_test.sv */
// Self-checking bench: random instruction and data scans through the port.
// Assumes jtp_tap, jtp_host_model and jtp_tap_chk are compiled first.
`timescale 1ns/1ps
`default_nettype none
module jtag_tap_controller_test;
  import jtp_pkg::*;
  localparam logic [31:0] ID_TB = 32'h5A3C_0E01; // Arbitrary, lsb one
  logic clock_i = 1'b0, reset_i = 1'b1, ce_i = 1'b1;
  logic port_enable_fuse_i = 1'b1, port_disable_bit_i = 1'b0;
  logic tck_i, tms_i, tdi_i, tdo_o, tdo_oe_o, port_active_o, pins_as_io_o, tap_pullup_o;
  logic chain_capture_o, chain_shift_o, chain_update_o, chain_tdi_o, instr_new_o, run_idle_o;
  logic [3:0] chain_sel_o, chain_tdo_i, instr_o, ext_mask;
  logic [31:0] ext_q, ext_cap;
  int n_errors = 0;
  int check_count = 0;
  int n_new = 0;
  int seed = 32'hEC4C_8011;
  always #12.5 clock_i = ~clock_i;
  // Update pulses seen in the system domain, one per loaded instruction
  always @(posedge clock_i) if (instr_new_o === 1'b1) n_new++;
  jtp_tap #(.ID_VALUE(ID_TB)) uut (.*);
  // Released TDO floats to the board pull-up, so the host then reads ones
  jtp_host_model host (.tck_o(tck_i), .tms_o(tms_i), .tdi_o(tdi_i), .tdo_i(tdo_oe_o ? tdo_o : 1'b1),
                       .sys_reset_i(reset_i));
  // External chain stand-in; answers only on the expected select line
  assign chain_tdo_i = ext_q[0] ? ext_mask : 4'h0;
  always @(posedge tck_i) begin
    if (chain_capture_o) ext_q <= ext_cap;
    else if (chain_shift_o) ext_q <= {chain_tdi_o, ext_q[31:1]};
  end
  function automatic logic [3:0] exp_sel(input logic [3:0] ins);
    case (ins)
      INS_EXTEST, INS_SAMPLE: exp_sel = 4'h1;
      4'h4, 4'h5, 4'h6, INS_PROG_HI: exp_sel = 4'h2;
      INS_ISCAN_LO, INS_ISCAN_HI: exp_sel = 4'h4;
      INS_BPSCN_LO, INS_BPSCN_HI: exp_sel = 4'h8;
      default: exp_sel = 4'h0;
    endcase
  endfunction : exp_sel
  // Bypass captures zero, then echoes tdi one bit late
  function automatic logic [31:0] exp_dr(input logic [3:0] ins, input logic [31:0] din);
    if (ins == INS_IDCODE) exp_dr = ID_TB;
    else if (exp_sel(ins) != 4'h0) exp_dr = ext_cap;
    else exp_dr = {din[30:0], 1'b0};
  endfunction : exp_dr
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic test_done;
    if (n_errors == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : test_done
  initial begin
    logic [31:0] din, dout;
    logic [3:0] ins, cap;
    // Reset held until link edges carry it across
    repeat (3) @(negedge clock_i);
    host.walk(8'hFF, 4);
    @(negedge clock_i) reset_i = 1'b0;
    repeat (10) @(negedge clock_i);
    chk("tap_pullup_o", 1, tap_pullup_o);
    host.walk(8'h1F, 6);
    for (int k = 0; k < 24; k++) begin
      ins = (k < 16) ? 4'(k) : 4'($random(seed));
      din = $random(seed);
      ext_cap = $random(seed);
      ext_mask = exp_sel(ins);
      host.ir_scan(ins, cap);
      chk("ir capture", IR_CAPTURE, cap);
      if (din[0]) host.walk(8'h00, 1);
      host.dr_scan(din, din[1], dout);
      chk("dr data", exp_dr(ins, din), dout);
      chk("chain_sel_o", exp_sel(ins), chain_sel_o);
      host.walk(8'h00, 1);
      repeat (8) @(negedge clock_i);
      chk("instr_o", ins, instr_o);
      chk("run_idle_o", 1, run_idle_o);
      chk("instr_new_o count", k + 1, n_new);
    end
    // Five ones from Shift-DR bring back the identification register
    host.ir_scan(INS_BYPASS, cap);
    host.walk(8'hF9, 8);
    // One zero leaves Test-Logic-Reset for idle before the data scan
    host.walk(8'h00, 1);
    host.dr_scan(din, 1'b0, dout);
    chk("dr after ones", ID_TB, dout);
    chk("instr_o after ones", INS_IDCODE, instr_o);
    // Fuse off, then disable set: port held, tdo quiet
    for (int m = 0; m < 2; m++) begin
      @(negedge clock_i);
      port_enable_fuse_i = (m == 1);
      port_disable_bit_i = (m == 1);
      repeat (8) @(negedge clock_i);
      chk("pins_as_io_o", 1, pins_as_io_o);
      host.ir_scan(INS_BYPASS, cap);
      host.dr_scan(din, 1'b0, dout);
      chk("held tdo", 32'hFFFF_FFFF, dout);
      @(negedge clock_i);
      port_enable_fuse_i = 1'b1;
      port_disable_bit_i = 1'b0;
      repeat (8) @(negedge clock_i);
      // Ones let the hold clear, the final zero moves on to idle
      host.walk(8'h0F, 5);
      host.dr_scan(din, 1'b0, dout);
      chk("id after hold", ID_TB, dout);
    end
    chk("resets seen", 1, host.resets_seen);
    test_done();
  end
  // Watchdog well beyond the expected run of about 0.25 ms
  initial begin
    #1_000_000;
    n_errors++;
    test_done();
  end
endmodule : jtag_tap_controller_test
bind jtp_tap jtp_tap_chk chk (.*);
`default_nettype wire

/* sim/jtp_host_model.sv */
// Behavioural external test controller driving the link pins.
// Assumes the bench calls its tasks; the link clock stands still between them.
`timescale 1ns/1ps
`default_nettype none
module jtp_host_model (
  // Link pins
  output logic      tck_o,
  output logic      tms_o,
  output logic      tdi_o,
  input  wire logic tdo_i,
  // System reset line
  input  wire logic sys_reset_i
);
  // the debugger watches the system reset line for outside resets
  int resets_seen = 0;
  always @(negedge sys_reset_i) resets_seen++;
  // Idle tms and tdi lines sit at the pulled-up level, tck rests low
  initial begin
    tck_o = 1'b0;
    tms_o = 1'b1;
    tdi_o = 1'b1;
  end
  // One 160 ns period; tdo read just before the rising edge
  task automatic bit_io(input logic m, input logic d, output logic q);
    tms_o = m;
    tdi_o = d;
    #80 q = tdo_i;
    tck_o = 1'b1;
    #80 tck_o = 1'b0;
  endtask : bit_io
  // Step tms through a list, first entry in bit 0
  task automatic walk(input logic [7:0] seq, input int n);
    logic q;
    for (int i = 0; i < n; i++) bit_io(seq[i], 1'b1, q);
  endtask : walk
  // lsb first, tms high with the last bit and, with pz, with bit 7
  task automatic shift(input int n, input logic [31:0] din, input logic pz, output logic [31:0] dout);
    for (int i = 0; i < n; i++) begin
      bit_io(i == n - 1 || (pz && i == 7), din[i], dout[i]);
      // detour through pause and back into shift
      if (pz && i == 7) walk(8'h04, 4);
    end
  endtask : shift
  task automatic ir_scan(input logic [3:0] ins, output logic [3:0] cap);
    logic [31:0] q;
    walk(8'h03, 4);
    shift(4, {28'h0, ins}, 1'b0, q);
    walk(8'h01, 1);
    cap = q[3:0];
  endtask : ir_scan
  // data scan from idle or an update state, stops in Update-DR
  task automatic dr_scan(input logic [31:0] din, input logic pz, output logic [31:0] dout);
    walk(8'h01, 3);
    shift(32, din, pz, dout);
    walk(8'h01, 1);
  endtask : dr_scan
endmodule : jtp_host_model
`default_nettype wire

/* sim/jtp_tap_chk.sv */
// Checker on the port pins and chain strobes of the test access port.
// Assumes it is bound to jtp_tap; link checks run on tck_i only.
`timescale 1ns/1ps
`default_nettype none
module jtp_tap_chk
  import jtp_pkg::*;
(
  // Watched ports
  input wire logic                  clock_i,
  input wire logic                  reset_i,
  input wire logic                  port_enable_fuse_i,
  input wire logic                  tck_i,
  input wire logic                  tms_i,
  input wire logic                  tdi_i,
  input wire logic                  tdo_o,
  input wire logic                  tdo_oe_o,
  input wire logic                  port_active_o,
  input wire logic                  pins_as_io_o,
  input wire logic                  tap_pullup_o,
  input wire logic [EXT_CHAINS-1:0] chain_sel_o,
  input wire logic                  chain_capture_o,
  input wire logic                  chain_shift_o,
  input wire logic                  chain_update_o,
  input wire logic                  chain_tdi_o,
  input wire logic [IR_W-1:0]       instr_o,
  input wire logic                  instr_new_o,
  input wire logic                  run_idle_o
);
  // Link domain: strobes, output enable, state steps
  AST_OE_SHIFT: assert property (@(posedge tck_i) disable iff (reset_i)
    chain_shift_o |-> tdo_oe_o) else $error("tdo not driven in shift");
  AST_OE_QUIET: assert property (@(posedge tck_i) disable iff (reset_i)
    (chain_capture_o || chain_update_o) |-> !tdo_oe_o) else $error("tdo driven outside shift");
  AST_TDO_ZERO: assert property (@(posedge tck_i) disable iff (reset_i)
    !tdo_oe_o |-> !tdo_o) else $error("tdo not low while released");
  AST_CAP_SHIFT: assert property (@(posedge tck_i) disable iff (reset_i)
    chain_capture_o && !tms_i |=> chain_shift_o) else $error("capture did not go to shift");
  AST_EXIT_QUIET: assert property (@(posedge tck_i) disable iff (reset_i)
    chain_shift_o && tms_i |=> !(chain_capture_o || chain_shift_o || chain_update_o))
    else $error("exit state caused a chain action");
  AST_UPD_ONCE: assert property (@(posedge tck_i) disable iff (reset_i)
    chain_update_o |=> !chain_update_o && !chain_shift_o) else $error("update held too long");
  AST_TLR_SEL: assert property (@(posedge tck_i) disable iff (reset_i)
    tms_i [*6] |=> chain_sel_o == 4'h0) else $error("tms ones did not reset instruction");
  AST_SEL_ONEHOT: assert property (@(posedge tck_i) disable iff (reset_i)
    $onehot0(chain_sel_o) && chain_tdi_o == tdi_i) else $error("bad chain select");
  // System domain: pin mode, reset values, update pulse
  AST_PIN_MODE: assert property (@(posedge clock_i) disable iff (reset_i)
    pins_as_io_o == !port_active_o && tap_pullup_o == port_active_o) else $error("pin mode mismatch");
  AST_HELD: assert property (@(posedge clock_i) disable iff (reset_i)
    !port_enable_fuse_i [*6] |-> !port_active_o) else $error("port active without fuse");
  AST_RESET_VALS: assert property (@(posedge clock_i)
    reset_i |=> instr_o == 4'h1 && !instr_new_o && !run_idle_o) else $error("bad reset values");
  AST_NEW_PULSE: assert property (@(posedge clock_i) disable iff (reset_i)
    instr_new_o |=> !instr_new_o) else $error("update pulse too long");
  // Main scenarios reached
  COV_UPD: cover property (@(posedge tck_i) chain_update_o);
  COV_EXIT: cover property (@(posedge tck_i) chain_shift_o && tms_i);
  COV_NEW: cover property (@(posedge clock_i) instr_new_o);
endmodule : jtp_tap_chk
`default_nettype wire
